//--- hdl/bto_agent.sv
// Bus agents on both sides: retry rotation, posted writes, sync reads
`timescale 1ns/1ps
module bto_agent
   import bto_pkg::*;
(
   // Clock and reset
   input  wire logic           i_core_clk,
   input  wire logic           i_rst,
   input  wire logic           i_ce,
   // Link to the bridge
   bto_if.agent                bus,
   // Mode
   input  wire logic           i_in_order,
   input  wire logic           i_sync_en,
   // Requests per direction
   input  wire logic     [1:0] i_req_valid,
   input  wire bto_txn_s [1:0] i_req_txn,
   output logic          [1:0] o_req_ready,
   // Arrivals per direction
   output logic          [1:0] o_got_valid,
   output bto_txn_s      [1:0] o_got_txn,
   input  wire logic     [1:0] i_got_ready
);
   bto_agent_s s_q;
   bto_agent_s s_d;

   always_comb begin
      bto_class_e cls;
      logic       user_pw;
      logic       sel;
      logic       free;
      logic       fidx;
      cls     = BTO_NONE;
      user_pw = 1'b0;
      sel     = 1'b0;
      free    = 1'b0;
      fidx    = 1'b0;
      s_d     = s_q;
      bus.in_valid  = '0;
      bus.in_txn    = '0;
      bus.out_ready = '0;
      o_req_ready   = '0;
      for (int d = 0; d < BTO_DIRS; d++) begin
         cls     = bto_classify(i_req_txn[d].cmd, i_req_txn[d].cpl);
         user_pw = i_req_valid[d] && (cls == BTO_PW) && !s_q.side[d].sync_pend;
         sel     = s_q.side[d].slot_v[s_q.side[d].rr] ? s_q.side[d].rr : !s_q.side[d].rr;
         free    = !(s_q.side[d].slot_v[0] && s_q.side[d].slot_v[1]);
         fidx    = s_q.side[d].slot_v[0];
         // RULE8 posted write goes out past pending retries
         if (user_pw) begin
            bus.in_valid[d] = 1'b1;
            bus.in_txn[d]   = i_req_txn[d];
            o_req_ready[d]  = bus.in_ready[d];
            if (bus.in_ready[d] && i_sync_en) begin
               s_d.side[d].sync_pend = 1'b1;
               s_d.side[d].sync_addr = i_req_txn[d].data;
            end
         end else if (s_q.side[d].slot_v != 2'h0) begin
            bus.in_valid[d] = 1'b1;
            bus.in_txn[d]   = s_q.side[d].slot[sel];
            if (bus.in_ready[d]) begin
               s_d.side[d].slot_v[sel] = 1'b0;
            end
         end
         // RULE5 rotate retries every attempt
         if (!user_pw && s_q.side[d].slot_v != 2'h0) begin
            s_d.side[d].rr = !sel;
         end
         // RULE18 read back after a posted write
         if (s_q.side[d].sync_pend && free) begin
            s_d.side[d].slot[fidx]   = '{cmd: BTO_CMD_MRD, cpl: 1'b0,
                                         data: s_q.side[d].sync_addr};
            s_d.side[d].slot_v[fidx] = 1'b1;
            s_d.side[d].sync_pend    = 1'b0;
         // RULE4 one delayed request at a time
         end else if (cls != BTO_PW && cls != BTO_NONE && !s_q.side[d].sync_pend &&
                      free && !(i_in_order && s_q.side[d].slot_v != 2'h0)) begin
            o_req_ready[d] = 1'b1;
            if (i_req_valid[d]) begin
               s_d.side[d].slot[fidx]   = i_req_txn[d];
               s_d.side[d].slot_v[fidx] = 1'b1;
            end
         end
         bus.out_ready[d] = !s_q.side[d].got_v || i_got_ready[d];
         if (bus.out_ready[d]) begin
            s_d.side[d].got_v = bus.out_valid[d];
            if (bus.out_valid[d]) begin
               s_d.side[d].got = bus.out_txn[d];
            end
         end
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         s_q <= '0;
      end else if (i_ce) begin
         s_q <= s_d;
      end
   end

   for (genvar g = 0; g < BTO_DIRS; g++) begin : g_out
      assign o_got_valid[g] = s_q.side[g].got_v;
      assign o_got_txn[g]   = s_q.side[g].got;
   end
endmodule // bto_agent

//--- hdl/bto_bridge.sv
// Ordering engine: posted and delayed queues per crossing direction
`timescale 1ns/1ps

// How it works
// RULE1: Order only transactions crossing the bridge
// RULE2: Order fixed when transaction completes
// RULE3: Retried requests hold no ordering position
// RULE4: Initiator waits before second delayed request
// RULE5: Initiator repeats all delayed requests fairly
// RULE6: Downstream and upstream writes independent
// RULE7: Accept and issue posted writes both sides
// RULE8: Posted write acceptance never waits on master
// RULE9: Posted writes accepted despite delayed progress
// RULE10: Posted writes issued in arrival order
// RULE11: Delayed read waits for earlier posted writes
// RULE12: Read completion waits for earlier posted writes
// RULE13: Delayed write never passes earlier posted write
// RULE14: Posted writes pass delayed, fair arbitration
// RULE15: Delayed requests and completions keep order
// RULE16: Write completion may pass posted writes
// RULE17: Order within direction, completions travel back
// RULE18: Follow posted writes with a read
// RULE19: Classify commands as posted, delayed read/write
// RULE20: Never combine, merge or collapse writes
// RULE21: Round-robin when both queues eligible
module bto_bridge
   import bto_pkg::*;
(
   // Clock and reset
   input  wire logic       i_core_clk,
   input  wire logic       i_rst,
   input  wire logic       i_ce,
   // Link to the bus agents
   bto_if.bridge           bus,
   // Queue status
   output logic [1:0][2:0] o_pw_count,
   output logic [1:0][2:0] o_dq_count
);
   bto_bridge_s    s_q;
   bto_bridge_s    s_d;
   logic     [1:0] b_in_valid;
   logic     [1:0] b_in_ready;
   bto_txn_s [1:0] b_in_txn;

   always_comb begin
      bto_class_e in_cls;
      bto_class_e hd_cls;
      logic       take;
      logic       pw_ok;
      logic       dq_ok;
      logic       pick_dq;
      logic       pw_pop;
      logic       dq_pop;
      in_cls  = BTO_NONE;
      hd_cls  = BTO_NONE;
      take    = 1'b0;
      pw_ok   = 1'b0;
      dq_ok   = 1'b0;
      pick_dq = 1'b0;
      pw_pop  = 1'b0;
      dq_pop  = 1'b0;
      s_d     = s_q;
      b_in_valid = '0;
      b_in_txn   = '0;
      bus.in_ready = '0;
      // RULE6 lanes share nothing
      // RULE7 both lanes move in one cycle
      // RULE17 one lane per direction of travel
      for (int d = 0; d < BTO_DIRS; d++) begin
         // RULE19 class from command
         in_cls = bto_classify(bus.in_txn[d].cmd, bus.in_txn[d].cpl);
         // RULE9 posted room ignores delayed queue
         // RULE8 no wait on master side
         if (in_cls == BTO_PW) begin
            bus.in_ready[d] = (s_q.lane[d].pw_n != BTO_FULL_N);
         end else if (in_cls != BTO_NONE) begin
            bus.in_ready[d] = (s_q.lane[d].dq_n != BTO_FULL_N);
         end
         // RULE1 only crossing traffic reaches a lane
         // RULE3 refused attempt leaves no entry
         take = bus.in_valid[d] && bus.in_ready[d];

         hd_cls = bto_classify(s_q.lane[d].dq[s_q.lane[d].dq_rd].txn.cmd,
                               s_q.lane[d].dq[s_q.lane[d].dq_rd].txn.cpl);
         pw_ok  = (s_q.lane[d].pw_n != BTO_ZERO_N);
         // RULE11 RULE12 RULE13 posted barrier
         // RULE16 write completion exempt
         dq_ok  = (s_q.lane[d].dq_n != BTO_ZERO_N) &&
                  (!bto_waits_pw(hd_cls) ||
                   s_q.lane[d].dq[s_q.lane[d].dq_rd].cnt == BTO_ZERO_N);
         // RULE14 RULE21 alternate when both eligible
         pick_dq = dq_ok && (!pw_ok || s_q.lane[d].rr_dq);
         b_in_valid[d] = pw_ok || dq_ok;
         // RULE20 one entry, one issued transaction
         b_in_txn[d]   = pick_dq ? s_q.lane[d].dq[s_q.lane[d].dq_rd].txn
                                 : s_q.lane[d].pw[s_q.lane[d].pw_rd];
         pw_pop = b_in_valid[d] && b_in_ready[d] && !pick_dq;
         dq_pop = b_in_valid[d] && b_in_ready[d] && pick_dq;
         if (pw_ok && dq_ok && b_in_ready[d]) begin
            s_d.lane[d].rr_dq = !pick_dq;
         end

         // RULE10 posted FIFO order
         if (pw_pop) begin
            s_d.lane[d].pw_rd = s_q.lane[d].pw_rd + BTO_PTR_ONE;
            for (int i = 0; i < BTO_DEPTH; i++) begin
               if (s_q.lane[d].dq[i].cnt != BTO_ZERO_N) begin
                  s_d.lane[d].dq[i].cnt = s_q.lane[d].dq[i].cnt - BTO_ONE_N;
               end
            end
         end
         // RULE15 single delayed FIFO per lane
         if (dq_pop) begin
            s_d.lane[d].dq_rd = s_q.lane[d].dq_rd + BTO_PTR_ONE;
         end

         // RULE2 position fixed on acceptance
         if (take && in_cls == BTO_PW) begin
            s_d.lane[d].pw[s_q.lane[d].pw_wr] = bus.in_txn[d];
            s_d.lane[d].pw_wr = s_q.lane[d].pw_wr + BTO_PTR_ONE;
         end else if (take) begin
            s_d.lane[d].dq[s_q.lane[d].dq_wr].txn = bus.in_txn[d];
            s_d.lane[d].dq[s_q.lane[d].dq_wr].cnt =
               pw_pop ? s_q.lane[d].pw_n - BTO_ONE_N : s_q.lane[d].pw_n;
            s_d.lane[d].dq_wr = s_q.lane[d].dq_wr + BTO_PTR_ONE;
         end

         if ((take && in_cls == BTO_PW) && !pw_pop) begin
            s_d.lane[d].pw_n = s_q.lane[d].pw_n + BTO_ONE_N;
         end else if (!(take && in_cls == BTO_PW) && pw_pop) begin
            s_d.lane[d].pw_n = s_q.lane[d].pw_n - BTO_ONE_N;
         end
         if ((take && in_cls != BTO_PW) && !dq_pop) begin
            s_d.lane[d].dq_n = s_q.lane[d].dq_n + BTO_ONE_N;
         end else if (!(take && in_cls != BTO_PW) && dq_pop) begin
            s_d.lane[d].dq_n = s_q.lane[d].dq_n - BTO_ONE_N;
         end
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         s_q <= '0;
      end else if (i_ce) begin
         s_q <= s_d;
      end
   end

   // Receiver stall lands in the buffer, not on a lost word
   for (genvar g = 0; g < BTO_DIRS; g++) begin : g_lane
      bto_buf u_buf (
         .i_core_clk (i_core_clk),
         .i_rst      (i_rst),
         .i_ce       (i_ce),
         .i_valid    (b_in_valid[g]),
         .o_ready    (b_in_ready[g]),
         .i_txn      (b_in_txn[g]),
         .o_valid    (bus.out_valid[g]),
         .i_ready    (bus.out_ready[g]),
         .o_txn      (bus.out_txn[g])
      );
      assign o_pw_count[g] = s_q.lane[g].pw_n;
      assign o_dq_count[g] = s_q.lane[g].dq_n;
   end
endmodule // bto_bridge

//--- hdl/bto_buf.sv
// Two-entry buffer on the issue path of one direction
`timescale 1ns/1ps
module bto_buf
   import bto_pkg::*;
(
   // Clock and reset
   input  wire logic     i_core_clk,
   input  wire logic     i_rst,
   input  wire logic     i_ce,
   // Fill side
   input  wire logic     i_valid,
   output logic          o_ready,
   input  wire bto_txn_s i_txn,
   // Drain side
   output logic          o_valid,
   input  wire logic     i_ready,
   output bto_txn_s      o_txn
);
   bto_buf_s s_q;
   bto_buf_s s_d;
   logic     push;
   logic     pop;

   assign o_ready = (s_q.n != BTO_BUF_N2);
   assign o_valid = (s_q.n != 2'h0);
   assign o_txn   = s_q.mem[s_q.rd];

   always_comb begin
      s_d  = s_q;
      push = i_valid && o_ready;
      pop  = o_valid && i_ready;
      if (push) begin
         s_d.mem[s_q.wr] = i_txn;
         s_d.wr          = ~s_q.wr;
      end
      if (pop) begin
         s_d.rd = ~s_q.rd;
      end
      if (push && !pop) begin
         s_d.n = s_q.n + BTO_BUF_ONE;
      end else if (pop && !push) begin
         s_d.n = s_q.n - BTO_BUF_ONE;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         s_q <= '0;
      end else if (i_ce) begin
         s_q <= s_d;
      end
   end
endmodule // bto_buf

//--- hdl/bto_if.sv
// Link between the bridge ordering engine and the bus agents
`timescale 1ns/1ps
interface bto_if;
   import bto_pkg::*;
   // Index 0 downstream, 1 upstream
   logic     [1:0] in_valid;
   logic     [1:0] in_ready;
   bto_txn_s [1:0] in_txn;
   logic     [1:0] out_valid;
   logic     [1:0] out_ready;
   bto_txn_s [1:0] out_txn;

   modport bridge (input in_valid, input in_txn, input out_ready,
                   output in_ready, output out_valid, output out_txn);
   modport agent  (output in_valid, output in_txn, output out_ready,
                   input in_ready, input out_valid, input out_txn);
endinterface

//--- hdl/bto_pkg.sv
// Shared types, command codes and helpers for the bridge ordering ends
package bto_pkg;

   localparam int          BTO_DIRS    = 2;
   localparam int          BTO_DEPTH   = 4;
   localparam int          BTO_SLOTS   = 2;
   localparam int          BTO_DIR_DN  = 0;
   localparam int          BTO_DIR_UP  = 1;
   localparam logic [2:0]  BTO_FULL_N  = 3'h4;
   localparam logic [2:0]  BTO_ZERO_N  = 3'h0;
   localparam logic [2:0]  BTO_ONE_N   = 3'h1;
   localparam logic [1:0]  BTO_PTR_ONE = 2'h1;
   localparam logic [1:0]  BTO_BUF_N2  = 2'h2;
   localparam logic [1:0]  BTO_BUF_ONE = 2'h1;

   // Bus command codes
   typedef logic [3:0] bto_cmd_t;
   localparam bto_cmd_t BTO_CMD_IORD  = 4'h2;
   localparam bto_cmd_t BTO_CMD_IOWR  = 4'h3;
   localparam bto_cmd_t BTO_CMD_MRD   = 4'h6;
   localparam bto_cmd_t BTO_CMD_MWR   = 4'h7;
   localparam bto_cmd_t BTO_CMD_CFGRD = 4'hA;
   localparam bto_cmd_t BTO_CMD_CFGWR = 4'hB;
   localparam bto_cmd_t BTO_CMD_MRDM  = 4'hC;
   localparam bto_cmd_t BTO_CMD_MRDL  = 4'hE;
   localparam bto_cmd_t BTO_CMD_MWI   = 4'hF;

   typedef enum logic [2:0] {
      BTO_PW, BTO_DRR, BTO_DWR, BTO_DRC, BTO_DWC, BTO_NONE
   } bto_class_e;

   typedef struct packed {
      bto_cmd_t    cmd;
      logic        cpl;
      logic [31:0] data;
   } bto_txn_s;

   typedef struct packed {
      bto_txn_s   txn;
      logic [2:0] cnt;
   } bto_ent_s;

   // RULE19 command to class mapping
   function automatic bto_class_e bto_classify(input bto_cmd_t cmd, input logic cpl);
      bto_class_e c;
      c = BTO_NONE;
      unique case (cmd)
         BTO_CMD_MWR, BTO_CMD_MWI:                       c = cpl ? BTO_NONE : BTO_PW;
         BTO_CMD_IOWR, BTO_CMD_CFGWR:                    c = cpl ? BTO_DWC : BTO_DWR;
         BTO_CMD_IORD, BTO_CMD_CFGRD, BTO_CMD_MRD,
         BTO_CMD_MRDM, BTO_CMD_MRDL:                     c = cpl ? BTO_DRC : BTO_DRR;
         default:                                        c = BTO_NONE;
      endcase
      return c;
   endfunction

   // Classes that wait behind earlier posted writes
   function automatic logic bto_waits_pw(input bto_class_e c);
      return (c == BTO_DRR) || (c == BTO_DWR) || (c == BTO_DRC);
   endfunction

   typedef struct packed {
      bto_txn_s [3:0] pw;
      bto_ent_s [3:0] dq;
      logic [1:0]     pw_rd;
      logic [1:0]     pw_wr;
      logic [2:0]     pw_n;
      logic [1:0]     dq_rd;
      logic [1:0]     dq_wr;
      logic [2:0]     dq_n;
      logic           rr_dq;
   } bto_lane_s;

   typedef struct packed {
      bto_lane_s [1:0] lane;
   } bto_bridge_s;

   typedef struct packed {
      bto_txn_s [1:0] mem;
      logic           rd;
      logic           wr;
      logic [1:0]     n;
   } bto_buf_s;

   typedef struct packed {
      bto_txn_s [1:0] slot;
      logic [1:0]     slot_v;
      logic           rr;
      logic           sync_pend;
      logic [31:0]    sync_addr;
      bto_txn_s       got;
      logic           got_v;
   } bto_side_s;

   typedef struct packed {
      bto_side_s [1:0] side;
   } bto_agent_s;

endpackage

//--- sim/bto_properties.sv
// Checker for the link between the ordering engine and the bus agents
`timescale 1ns/1ps
module bto_properties
   import bto_pkg::*;
(
   // Clock and reset
   input wire logic            i_core_clk,
   input wire logic            i_rst,
   // Link signals
   input wire logic      [1:0] in_valid,
   input wire logic      [1:0] in_ready,
   input wire bto_txn_s  [1:0] in_txn,
   input wire logic      [1:0] out_valid,
   input wire logic      [1:0] out_ready,
   input wire bto_txn_s  [1:0] out_txn,
   // Queue status
   input wire logic [1:0][2:0] o_pw_count,
   input wire logic [1:0][2:0] o_dq_count
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);

   function automatic logic is_pw(input bto_txn_s t);
      return (t.cmd == 4'h7 || t.cmd == 4'hF) && !t.cpl;
   endfunction

   function automatic logic is_dl(input bto_txn_s t);
      return t.cmd inside {4'h2, 4'h3, 4'h6, 4'hA, 4'hB, 4'hC, 4'hE};
   endfunction

   for (genvar d = 0; d < 2; d++) begin : g_lane
      property p_hold_v;
         out_valid[d] && !out_ready[d] |=> out_valid[d];
      endproperty
      property p_hold_t;
         out_valid[d] && !out_ready[d] |=> $stable(out_txn[d]);
      endproperty
      property p_first;
         o_pw_count[d] == 3'h0 && o_dq_count[d] == 3'h0 && !out_valid[d]
            && in_valid[d] && in_ready[d] && is_pw(in_txn[d]) |-> ##2 out_valid[d];
      endproperty
      property p_idle;
         o_pw_count[d] == 3'h0 && o_dq_count[d] == 3'h0 && !out_valid[d] |=> !out_valid[d];
      endproperty
      property p_pw_room;
         in_valid[d] && is_pw(in_txn[d]) && o_pw_count[d] < 3'h4 |-> in_ready[d];
      endproperty
      property p_pw_full;
         in_valid[d] && is_pw(in_txn[d]) && o_pw_count[d] == 3'h4 |-> !in_ready[d];
      endproperty
      property p_dq_room;
         in_valid[d] && is_dl(in_txn[d]) && o_dq_count[d] < 3'h4 |-> in_ready[d];
      endproperty
      property p_dq_full;
         in_valid[d] && is_dl(in_txn[d]) && o_dq_count[d] == 3'h4 |-> !in_ready[d];
      endproperty
      property p_out_class;
         out_valid[d] |-> is_pw(out_txn[d]) || is_dl(out_txn[d]);
      endproperty
      a_hold_v: assert property (p_hold_v) else $error("output dropped while stalled");
      a_hold_t: assert property (p_hold_t) else $error("output changed while stalled");
      a_first: assert property (p_first) else $error("posted write not issued in time");
      a_idle: assert property (p_idle) else $error("output from empty lane");
      a_pw_room: assert property (p_pw_room) else $error("posted write refused");
      a_pw_full: assert property (p_pw_full) else $error("posted write over depth");
      a_dq_room: assert property (p_dq_room) else $error("delayed refused");
      a_dq_full: assert property (p_dq_full) else $error("delayed over depth");
      a_out_class: assert property (p_out_class) else $error("bad issued class");
      c_pw_full: cover property (o_pw_count[d] == 3'h4);
      c_dq_full: cover property (o_dq_count[d] == 3'h4);
      c_retry: cover property (in_valid[d] && !in_ready[d]);
   end

   c_both: cover property (out_valid[0] && out_valid[1]);
endmodule // bto_properties

//--- sim/testbench.sv
// Self-checking bench joining the ordering engine and the bus agents
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
   $display("unexpected at %0t: got %0h want %0h", $time, (a), (b)); end end
module testbench;
   import bto_pkg::*;

   logic            core_clk = 1'b0;
   logic            rst      = 1'b1;
   logic            in_order = 1'b0;
   logic            sync_en  = 1'b0;
   logic      [1:0] req_v    = 2'h0;
   logic      [1:0] got_rdy  = 2'h0;
   bto_txn_s  [1:0] req_t    = '0;
   logic      [1:0] req_rdy;
   logic      [1:0] got_v;
   bto_txn_s  [1:0] got_t;
   logic [1:0][2:0] pw_n;
   logic [1:0][2:0] dq_n;
   int              fail_count = 0;
   int              checked    = 0;
   bto_txn_s        exp_q[$];

   always #10 core_clk = ~core_clk;

   bto_if u_bto_if ();

   bto_bridge u_bto_bridge (.i_core_clk(core_clk), .i_rst(rst), .i_ce(1'b1), .bus(u_bto_if),
      .o_pw_count(pw_n), .o_dq_count(dq_n));

   bto_agent u_bto_agent (.i_core_clk(core_clk), .i_rst(rst), .i_ce(1'b1), .bus(u_bto_if),
      .i_in_order(in_order), .i_sync_en(sync_en), .i_req_valid(req_v), .i_req_txn(req_t),
      .o_req_ready(req_rdy), .o_got_valid(got_v), .o_got_txn(got_t), .i_got_ready(got_rdy));

   bto_properties u_bto_properties (.i_core_clk(core_clk), .i_rst(rst),
      .in_valid(u_bto_if.in_valid), .in_ready(u_bto_if.in_ready), .in_txn(u_bto_if.in_txn),
      .out_valid(u_bto_if.out_valid), .out_ready(u_bto_if.out_ready),
      .out_txn(u_bto_if.out_txn), .o_pw_count(pw_n), .o_dq_count(dq_n));

   task automatic complete_run();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   function automatic bto_txn_s tx(input bto_cmd_t c, input logic p, input logic [31:0] v);
      return '{c, p, v};
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // Held until taken, as the agent contract asks
   task automatic send(input int d, input bto_txn_s t);
      int k;
      @(posedge core_clk);
      req_v[d] <= 1'b1;
      req_t[d] <= t;
      for (k = 0; k < 50; k++) begin
         @(posedge core_clk);
         if (req_rdy[d] === 1'b1) break;
      end
      if (k == 50) begin
         fail_count++;
         complete_run();
      end
      req_v[d] <= 1'b0;
   endtask

   task automatic expect_got(input int d, input bto_txn_s t);
      int k;
      for (k = 0; k < 200; k++) begin
         @(posedge core_clk);
         if (got_v[d] === 1'b1) break;
      end
      if (k == 200) begin
         fail_count++;
         complete_run();
      end
      `CHK(got_t[d], t)
      got_rdy[d] <= 1'b1;
      @(posedge core_clk);
      got_rdy[d] <= 1'b0;
   endtask

   // Fill one lane with the receiver stalled, then drain it
   task automatic t_fill(input int d, input logic pst);
      bto_txn_s t;
      int       k;
      bto_cmd_t dc[7] = '{4'h2, 4'h3, 4'hC, 4'hE, 4'hA, 4'hB, 4'h6};
      in_order <= ~pst;
      for (k = 0; k < 12; k++) begin
         if ((pst ? pw_n[d] : dq_n[d]) === BTO_FULL_N) break;
         t = tx(pst ? (k[0] ? BTO_CMD_MWI : BTO_CMD_MWR) : dc[k % 7], 1'b0, 32'h100 + k);
         send(d, t);
         exp_q.push_back(t);
         cyc(3);
      end
      `CHK(pst ? pw_n[d] : dq_n[d], BTO_FULL_N)
      if (pst) begin
         @(posedge core_clk);
         req_v[d] <= 1'b1;
         req_t[d] <= tx(BTO_CMD_MWR, 1'b0, 32'h200);
         for (k = 0; k < 4; k++) begin
            @(posedge core_clk);
            `CHK(req_rdy[d], 1'b0)
         end
         req_v[d] <= 1'b0;
      end else begin
         t = tx(BTO_CMD_MRD, 1'b0, 32'h200);
         send(d, t);
         exp_q.push_back(t);
         cyc(4);
         `CHK(dq_n[d], BTO_FULL_N)
      end
      while (exp_q.size() > 0) expect_got(d, exp_q.pop_front());
      cyc(3);
      `CHK(pw_n[d], BTO_ZERO_N)
      `CHK(dq_n[d], BTO_ZERO_N)
      in_order <= 1'b0;
   endtask

   // Three writes then a read or read completion behind them
   task automatic t_push(input int d, input bto_cmd_t rc, input logic rp);
      int k;
      for (k = 0; k < 3; k++) send(d, tx(BTO_CMD_MWR, 1'b0, 32'h300 + k));
      send(d, tx(rc, rp, 32'h300));
      for (k = 0; k < 3; k++) expect_got(d, tx(BTO_CMD_MWR, 1'b0, 32'h300 + k));
      expect_got(d, tx(rc, rp, 32'h300));
   endtask

   task automatic t_both();
      fork
         send(0, tx(BTO_CMD_MWR, 1'b0, 32'h400));
         send(1, tx(BTO_CMD_MWI, 1'b0, 32'h401));
      join
      expect_got(1, tx(BTO_CMD_MWI, 1'b0, 32'h401));
      expect_got(0, tx(BTO_CMD_MWR, 1'b0, 32'h400));
   endtask

   // Write completion passes a queued posted write, arbitration alternates
   task automatic t_pass();
      int k;
      for (k = 0; k < 5; k++) send(0, tx(BTO_CMD_MWR, 1'b0, 32'h500 + k));
      send(0, tx(BTO_CMD_IOWR, 1'b1, 32'h5FF));
      cyc(3);
      for (k = 0; k < 4; k++) expect_got(0, tx(BTO_CMD_MWR, 1'b0, 32'h500 + k));
      expect_got(0, tx(BTO_CMD_IOWR, 1'b1, 32'h5FF));
      expect_got(0, tx(BTO_CMD_MWR, 1'b0, 32'h504));
   endtask

   task automatic t_sync();
      sync_en <= 1'b1;
      send(0, tx(BTO_CMD_MWR, 1'b0, 32'h55));
      expect_got(0, tx(BTO_CMD_MWR, 1'b0, 32'h55));
      expect_got(0, tx(BTO_CMD_MRD, 1'b0, 32'h55));
      sync_en <= 1'b0;
   endtask

   initial begin
      cyc(8);
      rst <= 1'b0;
      t_fill(0, 1'b1);
      $display("test fill posted done");
      t_fill(1, 1'b0);
      $display("test fill delayed done");
      t_push(0, BTO_CMD_MRD, 1'b0);
      $display("test read behind writes done");
      t_push(1, BTO_CMD_CFGRD, 1'b1);
      $display("test completion behind writes done");
      t_both();
      $display("test both lanes done");
      t_pass();
      $display("test completion pass done");
      t_sync();
      $display("test sync read done");
      complete_run();
   end
endmodule // testbench
